// ### tlic_ctrl.sv
// Top of the two-level interrupt controller: register slave, event capture,
// request arbitration and vectoring handshake towards the CPU sequencer.
// Assumes all inputs are synchronous to ref_clk.
//
// The implementer's own choices: the Avalon-MM register port and the register offsets.
module tlic_ctrl
  import tlic_pkg::*;
#(
  parameter int CLKS_PER_INSTR = CLKS_PER_TCY
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Avalon-MM slave
  input wire logic [4:0] avs_address,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Event sources
  input wire logic timerZeroOverflow,
  input wire logic [2:0] extPins,
  input wire logic [3:0] upperPortBPins,
  input wire logic [NUM_PERIPH-1:0] periphEvent,
  // CPU sequencer
  input wire logic cpuBoundary,
  input wire logic returnFromService,
  output logic vectorLoad,
  output logic returnPush,
  output logic [VEC_W-1:0] vectorAddr,
  output logic instrTick
);
  logic ack_ff;
  logic [31:0] readdata_ff;
  logic [7:0] rdVal;
  logic wrStb;
  logic high_level_global_enable_ff;
  logic low_level_global_enable_ff;
  logic prioEn_ff;
  logic [2:0] edge_ff;
  logic [NUM_SRC-1:0] en_ff;
  logic [NUM_SRC-1:0] prio_ff;
  logic [2:0] extPrev_ff;
  logic [3:0] portPrev_ff;
  logic primed_ff;
  logic [$clog2(CLKS_PER_INSTR+1)-1:0] tick_ff;
  tlic_svc_e svc_ff;
  logic vecLoad_ff;
  logic [VEC_W-1:0] vecAddr_ff;
  logic [NUM_SRC-1:0] active;
  logic [NUM_SRC-1:0] group;
  logic hiReq;
  logic loReq;
  logic take;
  logic takeHigh;
  logic [2:0] extEdge;
  logic portChange;
  logic [3:0] pinEvt1_ff;
  logic [3:0] pinEvt2_ff;
  logic wrMain;
  logic wrC2;
  logic wrC3;
  logic wrRc;
  logic wrPf;
  logic wrPe;
  logic wrPp;
  logic [NUM_SRC-1:0] flagSet;

  tlic_flag_if #(.N(NUM_SRC)) flagIf();

  initial
  begin
    if (CLKS_PER_INSTR < 1) $error("CLKS_PER_INSTR must be at least one");
  end

  tlic_flag_bank #(.N(NUM_SRC)) uFlags (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .fl(flagIf.bank)
  );

  // One wait state: read data is captured first, then handed over.
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
  assign avs_readdata = readdata_ff;
  assign wrStb = avs_write & ack_ff & avs_byteenable[0];
  assign wrMain = wrStb && (avs_address == OFF_MAIN);
  assign wrC2 = wrStb && (avs_address == OFF_CTRL2);
  assign wrC3 = wrStb && (avs_address == OFF_CTRL3);
  assign wrRc = wrStb && (avs_address == OFF_RESET_CTL);
  assign wrPf = wrStb && (avs_address == OFF_PFLAGS);
  assign wrPe = wrStb && (avs_address == OFF_PENABLES);
  assign wrPp = wrStb && (avs_address == OFF_PPRIOS);

  // Access handshake.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      ack_ff <= 1'b0;
    else
      ack_ff <= (avs_read | avs_write) & ~ack_ff;
  end

  // Read mux; unmapped offsets and reserved bits read as zero.
  always_comb
  begin
    rdVal = 8'h00;
    unique case (avs_address)
      OFF_MAIN:
        rdVal = {high_level_global_enable_ff, low_level_global_enable_ff, en_ff[SRC_TMR0], en_ff[SRC_INT0], en_ff[SRC_PORT],
                 flagIf.flags[SRC_TMR0], flagIf.flags[SRC_INT0], flagIf.flags[SRC_PORT]};
      OFF_CTRL2:
        rdVal = {1'b0, edge_ff[0], edge_ff[1], edge_ff[2], 1'b0, prio_ff[SRC_TMR0], 1'b0, prio_ff[SRC_PORT]};
      OFF_CTRL3:
        rdVal = {prio_ff[SRC_INT2], prio_ff[SRC_INT1], 1'b0, en_ff[SRC_INT2], en_ff[SRC_INT1],
                 1'b0, flagIf.flags[SRC_INT2], flagIf.flags[SRC_INT1]};
      OFF_RESET_CTL:
        rdVal = {prioEn_ff, 7'h00};
      OFF_STATUS:
        rdVal = {4'h0, loReq, hiReq, (svc_ff == SVC_LOW) | (svc_ff == SVC_BOTH),
                 (svc_ff == SVC_HIGH) | (svc_ff == SVC_BOTH)};
      default:
        rdVal = 8'h00;
    endcase
  end

  // Capture read data in the first access cycle.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      readdata_ff <= 32'h00000000;
    else if (avs_read && !ack_ff)
    begin
      if (avs_address == OFF_PFLAGS)
        readdata_ff <= {22'h000000, flagIf.flags[NUM_SRC-1:SRC_PERIPH0]};
      else if (avs_address == OFF_PENABLES)
        readdata_ff <= {22'h000000, en_ff[NUM_SRC-1:SRC_PERIPH0]};
      else if (avs_address == OFF_PPRIOS)
        readdata_ff <= {22'h000000, prio_ff[NUM_SRC-1:SRC_PERIPH0]};
      else
        readdata_ff <= {24'h000000, rdVal};
    end
  end

  // Per-source enables and priorities; external pin 0 is always high level.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      en_ff <= '0;
      prio_ff <= PRIO_RESET;
      edge_ff <= 3'h7;
      prioEn_ff <= 1'b0;
    end
    else
    begin
      if (wrMain)
      begin
        en_ff[SRC_TMR0] <= avs_writedata[MC_TMR0_EN];
        en_ff[SRC_INT0] <= avs_writedata[MC_INT0_EN];
        en_ff[SRC_PORT] <= avs_writedata[MC_PORT_EN];
      end
      if (wrC2)
      begin
        edge_ff <= {avs_writedata[C2_EDGE2], avs_writedata[C2_EDGE1], avs_writedata[C2_EDGE0]};
        prio_ff[SRC_TMR0] <= avs_writedata[C2_TMR0_PRIO];
        prio_ff[SRC_PORT] <= avs_writedata[C2_PORT_PRIO];
      end
      if (wrC3)
      begin
        en_ff[SRC_INT2] <= avs_writedata[C3_INT2_EN];
        en_ff[SRC_INT1] <= avs_writedata[C3_INT1_EN];
        prio_ff[SRC_INT2] <= avs_writedata[C3_INT2_PRIO];
        prio_ff[SRC_INT1] <= avs_writedata[C3_INT1_PRIO];
      end
      if (wrRc)
        prioEn_ff <= avs_writedata[RC_PRIO_EN];
      if (wrPe)
        en_ff[NUM_SRC-1:SRC_PERIPH0] <= avs_writedata[NUM_PERIPH-1:0];
      if (wrPp)
        prio_ff[NUM_SRC-1:SRC_PERIPH0] <= avs_writedata[NUM_PERIPH-1:0];
    end
  end

  // Instruction-cycle divider; pins are sampled once per instruction cycle.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      tick_ff <= '0;
    else if (tick_ff == ($bits(tick_ff))'(CLKS_PER_INSTR - 1))
      tick_ff <= '0;
    else
      tick_ff <= tick_ff + 1'b1;
  end
  assign instrTick = (tick_ff == ($bits(tick_ff))'(CLKS_PER_INSTR - 1));

  // Previous pin levels; the first sample only primes them, avoiding a false edge.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      extPrev_ff <= 3'h0;
      portPrev_ff <= 4'h0;
      primed_ff <= 1'b0;
    end
    else if (instrTick)
    begin
      extPrev_ff <= extPins;
      portPrev_ff <= upperPortBPins;
      primed_ff <= 1'b1;
    end
  end

  // Edge detection on the external pins and the upper port pins.
  always_comb
  begin
    for (int i = 0; i < 3; i++)
      extEdge[i] = instrTick & primed_ff &
                   (edge_ff[i] ? (extPins[i] & ~extPrev_ff[i]) : (~extPins[i] & extPrev_ff[i]));
  end
  assign portChange = instrTick & primed_ff & (upperPortBPins != portPrev_ff);

  // Pin events wait two more instruction cycles before they set a flag.
  // This keeps pin-to-vector latency at three to four cycles while cpuBoundary is high at every instruction tick.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pinEvt1_ff <= 4'h0;
      pinEvt2_ff <= 4'h0;
    end
    else if (instrTick)
    begin
      pinEvt1_ff <= {portChange, extEdge};
      pinEvt2_ff <= pinEvt1_ff;
    end
  end

  // Event sets into the sticky flag bank, independent of every enable.
  always_comb
  begin
    flagSet = '0;
    flagSet[SRC_PORT] = instrTick & pinEvt2_ff[3];
    flagSet[SRC_INT0] = instrTick & pinEvt2_ff[0];
    flagSet[SRC_INT1] = instrTick & pinEvt2_ff[1];
    flagSet[SRC_INT2] = instrTick & pinEvt2_ff[2];
    flagSet[SRC_TMR0] = timerZeroOverflow;
    flagSet[NUM_SRC-1:SRC_PERIPH0] = periphEvent;
  end
  assign flagIf.setEvt = flagSet;

  // Software writes to the flags; a zero clears, hardware set still wins.
  always_comb
  begin
    flagIf.wrMask = '0;
    flagIf.wrData = '0;
    if (wrMain)
    begin
      flagIf.wrMask[SRC_TMR0] = 1'b1;
      flagIf.wrMask[SRC_INT0] = 1'b1;
      flagIf.wrMask[SRC_PORT] = 1'b1;
      flagIf.wrData[SRC_TMR0] = avs_writedata[MC_TMR0_FLAG];
      flagIf.wrData[SRC_INT0] = avs_writedata[MC_INT0_FLAG];
      flagIf.wrData[SRC_PORT] = avs_writedata[MC_PORT_FLAG];
    end
    if (wrC3)
    begin
      flagIf.wrMask[SRC_INT2] = 1'b1;
      flagIf.wrMask[SRC_INT1] = 1'b1;
      flagIf.wrData[SRC_INT2] = avs_writedata[C3_INT2_FLAG];
      flagIf.wrData[SRC_INT1] = avs_writedata[C3_INT1_FLAG];
    end
    if (wrPf)
    begin
      flagIf.wrMask[NUM_SRC-1:SRC_PERIPH0] = '1;
      flagIf.wrData[NUM_SRC-1:SRC_PERIPH0] = avs_writedata[NUM_PERIPH-1:0];
    end
  end

  // Request arbitration per flag, enable and priority.
  always_comb
  begin
    active = flagIf.flags & en_ff;
    group = '1;
    group[NUM_SRC-1:SRC_PERIPH0] = {NUM_PERIPH{low_level_global_enable_ff}};
    if (prioEn_ff)
    begin
      hiReq = high_level_global_enable_ff && |(active & prio_ff);
      loReq = low_level_global_enable_ff && high_level_global_enable_ff && (svc_ff == SVC_NONE) && |(active & ~prio_ff);
    end
    else
    begin
      hiReq = high_level_global_enable_ff && |(active & group);
      loReq = 1'b0;
    end
  end

  // Vectoring is taken at the next instruction boundary; high wins a tie.
  assign take = instrTick & cpuBoundary & (hiReq | loReq);
  assign takeHigh = hiReq;

  // Global enables: software writes, accept clears, return sets again.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      high_level_global_enable_ff <= 1'b0;
      low_level_global_enable_ff <= 1'b0;
    end
    else if (take)
    begin
      if (takeHigh)
        high_level_global_enable_ff <= 1'b0;
      else
        low_level_global_enable_ff <= 1'b0;
    end
    else if (returnFromService)
    begin
      if (!prioEn_ff || svc_ff == SVC_HIGH || svc_ff == SVC_BOTH)
        high_level_global_enable_ff <= 1'b1;
      else if (svc_ff == SVC_LOW)
        low_level_global_enable_ff <= 1'b1;
    end
    else if (wrMain)
    begin
      high_level_global_enable_ff <= avs_writedata[MC_HIGH_LEVEL_GLOBAL_ENABLE];
      low_level_global_enable_ff <= avs_writedata[MC_LOW_LEVEL_GLOBAL_ENABLE];
    end
  end

  // Service level tracking so a return restores the right enable.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      svc_ff <= SVC_NONE;
    else if (take)
    begin
      unique case (svc_ff)
        SVC_NONE:
          svc_ff <= takeHigh ? SVC_HIGH : SVC_LOW;
        SVC_LOW:
          svc_ff <= takeHigh ? SVC_BOTH : SVC_LOW;
        SVC_HIGH:
          svc_ff <= SVC_HIGH;
        SVC_BOTH:
          svc_ff <= SVC_BOTH;
        default:
          svc_ff <= SVC_NONE;
      endcase
    end
    else if (returnFromService)
    begin
      unique case (svc_ff)
        SVC_BOTH:
          svc_ff <= SVC_LOW;
        default:
          svc_ff <= SVC_NONE;
      endcase
    end
  end

  // Vector outputs towards the program counter and hardware stack.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      vecLoad_ff <= 1'b0;
      vecAddr_ff <= VEC_HIGH;
    end
    else
    begin
      vecLoad_ff <= take;
      if (take)
        vecAddr_ff <= (takeHigh || !prioEn_ff) ? VEC_HIGH : VEC_LOW;
    end
  end

  assign vectorLoad = vecLoad_ff;
  assign returnPush = vecLoad_ff;
  assign vectorAddr = vecAddr_ff;
endmodule : tlic_ctrl

// ### tlic_pkg.sv
// Constants, register map and types of the two-level interrupt controller.
// Assumes a single 200 MHz clock and an Avalon-MM master reaching the registers.
//
// Summary of operation
// - Fifteen sources, each high or low priority.
// - High vectors to 000008h, low to 000018h.
// - High preempts low service; never the reverse.
// - Each source has flag, enable, priority bits; external pin 0 has no priority bit and is always high.
// - High enable gates high sources, low gates low.
// - Flag, enable and global enable request vectoring.
// - Priority mode off: all vector to 000008h.
// - Compatibility: peripheral enable and global enable gate.
// - Accept clears the admitting global enable.
// - Accept pushes return address, loads vector.
// - Return instruction sets the global enable again.
// - Pin events vector in three to four cycles.
// - Flags set regardless of any enable bit.
// - Main control register bit layout 7 to 0.
// - Timer-0 overflow sets a sticky flag.
// - Upper port-B change sets a sticky flag.
// - Edge-select one rising, zero falling.
package tlic_pkg;
  // Source counts and vector addresses.
  localparam int NUM_SRC = 15;
  localparam int NUM_CORE = 5;
  localparam int NUM_PERIPH = 10;
  localparam int VEC_W = 21;
  localparam logic [VEC_W-1:0] VEC_HIGH = 21'h000008;
  localparam logic [VEC_W-1:0] VEC_LOW = 21'h000018;
  // Instruction cycle is four clocks of 5 ns each.
  localparam int CLK_PERIOD_NS = 5;
  localparam int TCY_NS = 20;
  localparam int CLKS_PER_TCY = TCY_NS / CLK_PERIOD_NS;
  // Register byte offsets.
  localparam logic [4:0] OFF_MAIN = 5'h00;
  localparam logic [4:0] OFF_CTRL2 = 5'h04;
  localparam logic [4:0] OFF_CTRL3 = 5'h08;
  localparam logic [4:0] OFF_RESET_CTL = 5'h0C;
  localparam logic [4:0] OFF_PFLAGS = 5'h10;
  localparam logic [4:0] OFF_PENABLES = 5'h14;
  localparam logic [4:0] OFF_PPRIOS = 5'h18;
  localparam logic [4:0] OFF_STATUS = 5'h1C;
  // Main control register fields.
  localparam int MC_HIGH_LEVEL_GLOBAL_ENABLE = 7;
  localparam int MC_LOW_LEVEL_GLOBAL_ENABLE = 6;
  localparam int MC_TMR0_EN = 5;
  localparam int MC_INT0_EN = 4;
  localparam int MC_PORT_EN = 3;
  localparam int MC_TMR0_FLAG = 2;
  localparam int MC_INT0_FLAG = 1;
  localparam int MC_PORT_FLAG = 0;
  // Second control register fields.
  localparam int C2_EDGE0 = 6;
  localparam int C2_EDGE1 = 5;
  localparam int C2_EDGE2 = 4;
  localparam int C2_TMR0_PRIO = 2;
  localparam int C2_PORT_PRIO = 0;
  localparam logic [7:0] C2_RESET = 8'h75;
  // Third control register fields, then the reset control priority-enable bit.
  localparam int C3_INT2_PRIO = 7;
  localparam int C3_INT1_PRIO = 6;
  localparam int C3_INT2_EN = 4;
  localparam int C3_INT1_EN = 3;
  localparam int C3_INT2_FLAG = 1;
  localparam int C3_INT1_FLAG = 0;
  localparam int RC_PRIO_EN = 7;
  // Source index in the flag, enable and priority vectors.
  localparam int SRC_PORT = 0;
  localparam int SRC_INT0 = 1;
  localparam int SRC_TMR0 = 2;
  localparam int SRC_INT1 = 3;
  localparam int SRC_INT2 = 4;
  localparam int SRC_PERIPH0 = 5;
  localparam logic [NUM_SRC-1:0] PRIO_RESET = 15'h7FFF;
  // Service level, one-hot.
  typedef enum logic [3:0] {
    SVC_NONE = 4'h1,
    SVC_LOW = 4'h2,
    SVC_HIGH = 4'h4,
    SVC_BOTH = 4'h8
  } tlic_svc_e;
endpackage : tlic_pkg

// ### tlic_flag_if.sv
// Interface between the controller and its sticky flag bank.
// Assumes both ends run on the same clock.
interface tlic_flag_if #(parameter int N = 15);
  logic [N-1:0] setEvt;
  logic [N-1:0] wrMask;
  logic [N-1:0] wrData;
  logic [N-1:0] flags;
  modport bank(input setEvt, input wrMask, input wrData, output flags);
  modport ctrl(output setEvt, output wrMask, output wrData, input flags);
endinterface : tlic_flag_if

// ### tlic_flag_bank.sv
// Bank of sticky interrupt flags written by software and set by events.
// Assumes event and write strobes are one-clock pulses on ref_clk.
module tlic_flag_bank
  import tlic_pkg::*;
#(
  parameter int N = 15
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Flag access
  tlic_flag_if.bank fl
);
  logic [N-1:0] flags_ff;

  initial
  begin
    if (N < 1) $error("flag bank needs at least one flag");
  end

  // A set arriving with a software write wins, so no event is lost.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      flags_ff <= '0;
    else
      flags_ff <= (fl.wrMask & fl.wrData) | (~fl.wrMask & flags_ff) | fl.setEvt;
  end

  assign fl.flags = flags_ff;
endmodule : tlic_flag_bank

// ### tlic_ctrl_chk.sv
// Checker for the interrupt controller top, watching its ports only.
// Assumes the bench master holds every bus request until waitrequest is low.
module tlic_ctrl_chk
  import tlic_pkg::*;
#(
  parameter int CLKS_PER_INSTR = CLKS_PER_TCY
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Register bus
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // CPU sequencer
  input wire logic cpuBoundary,
  input wire logic returnFromService,
  input wire logic vectorLoad,
  input wire logic returnPush,
  input wire logic [VEC_W-1:0] vectorAddr,
  input wire logic instrTick
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  int depth;
  int gap;
  logic seenTick;
  // Nesting depth of service routines, so a nested entry can be judged.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      depth <= 0;
    else if (vectorLoad && !returnFromService)
      depth <= depth + 1;
    else if (returnFromService && !vectorLoad && depth != 0)
      depth <= depth - 1;
  end
  // Clocks since the last instruction tick; the first tick after reset only arms it.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      gap <= 0;
      seenTick <= 1'b0;
    end
    else
    begin
      gap <= instrTick ? 0 : gap + 1;
      seenTick <= seenTick | instrTick;
    end
  end
  sequence s_req_open;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_accept_seen;
    $past(instrTick) && $past(cpuBoundary);
  endsequence
  property p_push_pair;
    vectorLoad == returnPush;
  endproperty
  property p_vec_legal;
    vectorLoad |-> (vectorAddr == VEC_HIGH || vectorAddr == VEC_LOW);
  endproperty
  property p_load_cause;
    vectorLoad |-> s_accept_seen;
  endproperty
  property p_load_pulse;
    vectorLoad |=> !vectorLoad;
  endproperty
  property p_addr_hold;
    $changed(vectorAddr) |-> vectorLoad;
  endproperty
  property p_no_low_nest;
    vectorLoad && depth != 0 |-> vectorAddr == VEC_HIGH;
  endproperty
  property p_one_wait;
    s_req_open |=> !avs_waitrequest;
  endproperty
  property p_rd_stable;
    $changed(avs_readdata) |-> $past(avs_read && avs_waitrequest);
  endproperty
  property p_tick_gap;
    instrTick && seenTick |-> gap == CLKS_PER_INSTR - 1;
  endproperty
  a_push_pair: assert property (p_push_pair) else $error("push and load differ");
  a_vec_legal: assert property (p_vec_legal) else $error("illegal vector");
  a_load_cause: assert property (p_load_cause) else $error("load without tick and boundary");
  a_load_pulse: assert property (p_load_pulse) else $error("load longer than one clock");
  a_addr_hold: assert property (p_addr_hold) else $error("vector moved without load");
  a_no_low_nest: assert property (p_no_low_nest) else $error("low vector nested");
  a_one_wait: assert property (p_one_wait) else $error("wait longer than one cycle");
  a_rd_stable: assert property (p_rd_stable) else $error("read data moved");
  a_tick_gap: assert property (p_tick_gap) else $error("tick spacing wrong");
endmodule : tlic_ctrl_chk

bind tlic_ctrl tlic_ctrl_chk #(.CLKS_PER_INSTR(CLKS_PER_INSTR)) u_tlic_ctrl_chk (.ref_clk(ref_clk),
  .resetn(resetn), .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .cpuBoundary(cpuBoundary), .returnFromService(returnFromService),
  .vectorLoad(vectorLoad), .returnPush(returnPush), .vectorAddr(vectorAddr), .instrTick(instrTick));

// ### tlic_cpu_model.sv
// Model of the CPU sequencer on the vectoring side of the controller.
// Assumes the same clock as the controller; the bench commands stalls and returns.
module tlic_cpu_model
  import tlic_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Bench control
  input wire logic stallBoundary,
  input wire logic retReq,
  // Controller side
  input wire logic vectorLoad,
  input wire logic [VEC_W-1:0] vectorAddr,
  output logic cpuBoundary,
  output logic returnFromService,
  output int loadCnt,
  output logic [VEC_W-1:0] lastVec
);
  timeunit 1ns;
  timeprecision 1ps;
  // Registered so the model changes just after an edge, as a real sequencer would.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cpuBoundary <= 1'b0;
      returnFromService <= 1'b0;
    end
    else
    begin
      cpuBoundary <= !stallBoundary;
      returnFromService <= retReq;
    end
  end
  // Each vector load is counted and its target kept for the bench to judge.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      loadCnt <= 0;
      lastVec <= '0;
    end
    else if (vectorLoad)
    begin
      loadCnt <= loadCnt + 1;
      lastVec <= vectorAddr;
    end
  end
endmodule : tlic_cpu_model

// ### tb_top.sv
// Self-checking bench for the interrupt controller with a sequencer model.
// Assumes a 200 MHz clock and a shortened instruction cycle.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import tlic_pkg::*;
  localparam int CLK = 2;
  logic ref_clk, resetn, avsRd, avsWr, avsWait, tmrOvf, bnd, rfs, vLoad, stall, retReq;
  logic [4:0] avsAddr;
  logic [31:0] avsWdata, avsRdata, q;
  logic [2:0] pins;
  logic [3:0] portB;
  logic [9:0] pEvt;
  logic [VEC_W-1:0] vAddr, lastVec;
  int error_cnt = 0;
  int samples_checked = 0;
  int loads, nExp = 0;

  tlic_ctrl #(.CLKS_PER_INSTR(CLK)) u_tlic_ctrl (.ref_clk(ref_clk), .resetn(resetn), .avs_address(avsAddr),
    .avs_byteenable(4'hF), .avs_read(avsRd), .avs_write(avsWr), .avs_writedata(avsWdata),
    .avs_readdata(avsRdata), .avs_waitrequest(avsWait), .timerZeroOverflow(tmrOvf), .extPins(pins),
    .upperPortBPins(portB), .periphEvent(pEvt), .cpuBoundary(bnd), .returnFromService(rfs),
    .vectorLoad(vLoad), .returnPush(), .vectorAddr(vAddr), .instrTick());
  tlic_cpu_model u_tlic_cpu_model (.ref_clk(ref_clk), .resetn(resetn), .stallBoundary(stall),
    .retReq(retReq), .vectorLoad(vLoad), .vectorAddr(vAddr), .cpuBoundary(bnd),
    .returnFromService(rfs), .loadCnt(loads), .lastVec(lastVec));

  // Free-running clock, 5 ns period.
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // One bus access; the request is held until waitrequest is seen low.
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    avsAddr <= a;
    avsWdata <= d;
    avsWr <= wr;
    avsRd <= !wr;
    do
    begin
      @(posedge ref_clk);
      n++;
    end while (avsWait !== 1'b0 && n < 50);
    q = avsRdata;
    avsWr <= 1'b0;
    avsRd <= 1'b0;
    if (n >= 50) chk("bus answer", 0, 1);
  endtask : bus

  task automatic rd(input logic [4:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, '0);
    chk(nm, e, q);
  endtask : rd

  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : idle

  task automatic pulse(input logic t, input logic p);
    @(posedge ref_clk);
    tmrOvf <= t;
    pEvt <= {9'h0, p};
    @(posedge ref_clk);
    tmrOvf <= 1'b0;
    pEvt <= '0;
  endtask : pulse

  task automatic ret();
    @(posedge ref_clk);
    retReq <= 1'b1;
    @(posedge ref_clk);
    retReq <= 1'b0;
  endtask : ret

  // Waits for the next vector load under a bound and judges its target.
  task automatic expLoad(input logic [VEC_W-1:0] v, input string nm);
    int k;
    k = 0;
    while (loads <= nExp && k < 60)
    begin
      @(posedge ref_clk);
      k++;
    end
    nExp++;
    chk({nm, " count"}, nExp, loads);
    chk(nm, v, lastVec);
  endtask : expLoad

  // Reset values and a write to the read-only status word.
  task automatic t_reset();
    rd(OFF_MAIN, 32'h00, "main reset");
    rd(OFF_CTRL2, 32'h75, "ctrl2 reset");
    rd(OFF_CTRL3, 32'hC0, "ctrl3 reset");
    rd(OFF_RESET_CTL, 32'h00, "prio enable reset");
    rd(OFF_PPRIOS, 32'h3FF, "prio reset");
    bus(1'b1, OFF_STATUS, 32'hFF);
    rd(OFF_STATUS, 32'h00, "status read only");
    $display("t_reset done");
  endtask : t_reset

  // Compatibility mode gating, a stalled sequencer and the return path.
  task automatic t_compat();
    pulse(1'b1, 1'b0);
    rd(OFF_MAIN, 32'h04, "timer flag unenabled");
    bus(1'b1, OFF_PENABLES, 32'h1);
    pulse(1'b0, 1'b1);
    bus(1'b1, OFF_MAIN, 32'h84);
    idle(12);
    chk("no peripheral load", nExp, loads);
    stall <= 1'b1;
    bus(1'b1, OFF_MAIN, 32'hC4);
    idle(12);
    chk("no load off boundary", nExp, loads);
    stall <= 1'b0;
    expLoad(VEC_HIGH, "compat vector");
    rd(OFF_MAIN, 32'h44, "global cleared");
    bus(1'b1, OFF_PFLAGS, 32'h0);
    bus(1'b1, OFF_MAIN, 32'h40);
    ret();
    rd(OFF_MAIN, 32'hC0, "global restored");
    bus(1'b1, OFF_MAIN, 32'h00);
    bus(1'b1, OFF_PENABLES, 32'h0);
    $display("t_compat done");
  endtask : t_compat

  // Two levels: simultaneous requests, low held off, high preempting low.
  task automatic t_prio();
    bus(1'b1, OFF_RESET_CTL, 32'h80);
    bus(1'b1, OFF_PPRIOS, 32'h0);
    bus(1'b1, OFF_PFLAGS, 32'h0);
    bus(1'b1, OFF_PENABLES, 32'h1);
    bus(1'b1, OFF_MAIN, 32'h20);
    pulse(1'b1, 1'b1);
    bus(1'b1, OFF_MAIN, 32'hE4);
    expLoad(VEC_HIGH, "high first");
    idle(12);
    chk("low held", nExp, loads);
    bus(1'b1, OFF_MAIN, 32'h60);
    ret();
    expLoad(VEC_LOW, "low vector");
    rd(OFF_MAIN, 32'hA0, "low enable cleared");
    pulse(1'b1, 1'b0);
    expLoad(VEC_HIGH, "high preempts");
    bus(1'b1, OFF_MAIN, 32'h00);
    bus(1'b1, OFF_PFLAGS, 32'h0);
    ret();
    ret();
    bus(1'b1, OFF_MAIN, 32'h00);
    bus(1'b1, OFF_RESET_CTL, 32'h00);
    bus(1'b1, OFF_PENABLES, 32'h0);
    $display("t_prio done");
  endtask : t_prio

  // Pin edges of both polarities, vectoring latency and port change.
  task automatic t_pins();
    int k;
    k = 0;
    bus(1'b1, OFF_MAIN, 32'h90);
    @(posedge ref_clk);
    pins[0] <= 1'b1;
    while (loads <= nExp && k < 60)
    begin
      @(posedge ref_clk);
      k++;
    end
    // The count moves two edges after the accepting edge, hence the offset.
    chk("pin latency", 1, k - 2 > 3 * CLK && k - 2 <= 4 * CLK);
    expLoad(VEC_HIGH, "pin vector");
    rd(OFF_MAIN, 32'h12, "rising edge flag");
    bus(1'b1, OFF_CTRL2, 32'h35);
    rd(OFF_CTRL2, 32'h35, "edge select readback");
    bus(1'b1, OFF_MAIN, 32'h00);
    ret();
    pins[0] <= 1'b0;
    idle(4 * CLK);
    rd(OFF_MAIN, 32'h82, "falling edge flag");
    portB[2] <= 1'b1;
    idle(4 * CLK);
    rd(OFF_MAIN, 32'h83, "port change flag");
    bus(1'b1, OFF_MAIN, 32'h00);
    $display("t_pins done");
  endtask : t_pins

  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim

  // Main sequence.
  initial
  begin
    {resetn, avsRd, avsWr, tmrOvf, stall, retReq} = '0;
    {avsAddr, avsWdata, pins, portB, pEvt} = '0;
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    t_reset();
    t_compat();
    t_prio();
    t_pins();
    end_sim();
  end

  // Watchdog well beyond the few hundred cycles the tests need.
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    end_sim();
  end
endmodule : tb_top
